// ===== logic/vbsc_pkg.sv
// Function
// - Any-long-type bit passes every long packet
// - Match enable passes packets equal to value
// - Match value writes blocked while matching enabled
// - YUV bit plus hundred mode passes 10-bit YUV
// - Bit 1 inverts frame-valid polarity
// - Bit 0 inverts line-valid polarity
// - Six-bit match value passes in either mode
// - Match only when programmed value is long
// - Inject bit inserts programmed parity error count
// - Entering self-test injects the errors automatically
// - Seven-bit error count field, resets to zero
// - Nonzero bits 7:4 enable forced errors
// - Local self-test bit forces self-test mode
// - Clock select: 00 system, 01 50MHz, 1X 25MHz
// - Bit 0 enables remote self-test
// - Gain is 128 over field, reset 0x20
// - Sensor enable field 00 off, 11 on
// - GPIO sensing select chooses GPIO0, GPIO1, both
// - Bit 7 applies sensor gain, resets one
package vbsc_pkg;

	// ************
	// Register offsets
	// ************
	localparam logic [7:0] OFS_VIDEO_FILTER_CONFIG    = 8'h10;
	localparam logic [7:0] OFS_VIDEO_TYPE_MATCH_VALUE = 8'h11;
	localparam logic [7:0] OFS_PARITY_ERROR_INJECTION = 8'h13;
	localparam logic [7:0] OFS_SELF_TEST_CONTROL      = 8'h14;
	localparam logic [7:0] OFS_SENSOR_VOLTAGE_GAIN    = 8'h15;
	localparam logic [7:0] OFS_SENSOR_CONTROL_FIRST   = 8'h17;
	localparam logic [7:0] OFS_SENSOR_CONTROL_SECOND  = 8'h18;

	// ************
	// Reset values and unmapped read value
	// ************
	localparam logic [7:0] RST_VIDEO_FILTER_CONFIG    = 8'h00;
	localparam logic [7:0] RST_VIDEO_TYPE_MATCH_VALUE = 8'h00;
	localparam logic [6:0] RST_INJECTED_ERROR_COUNT   = 7'h00;
	localparam logic [7:0] RST_SELF_TEST_CONTROL      = 8'h00;
	localparam logic [7:0] RST_SENSOR_VOLTAGE_GAIN    = 8'h20;
	localparam logic [7:0] RST_SENSOR_CONTROL_FIRST   = 8'h3c;
	localparam logic [7:0] RST_SENSOR_CONTROL_SECOND  = 8'h80;
	localparam logic [7:0] READ_UNMAPPED              = 8'h00;

	// ************
	// Field positions
	// ************
	localparam int BIT_ANY_LONG_TYPE_PASS = 4;
	localparam int BIT_TYPE_MATCH_ENABLE  = 3;
	localparam int BIT_YUV10_PASS_ENABLE  = 2;
	localparam int BIT_FRAME_VALID_INVERT = 1;
	localparam int BIT_LINE_VALID_INVERT  = 0;
	localparam int BIT_INJECT_PARITY_ERRS = 7;
	localparam int BIT_LOCAL_SELF_TEST    = 3;
	localparam int BIT_REMOTE_SELF_TEST   = 0;
	localparam int BIT_SENSE_GAIN_ENABLE  = 7;

	// ************
	// Packet data types and sensor enable code
	// ************
	localparam logic [5:0] DT_YUV10_A = 6'h19;
	localparam logic [5:0] DT_YUV10_B = 6'h1d;
	localparam logic [5:0] DT_YUV10_C = 6'h1f;
	localparam logic [1:0] SENSOR_ENABLED = 2'h3;

	typedef enum logic [1:0] {
		VBSC_CLK_SYSTEM,
		VBSC_CLK_INT_50M,
		VBSC_CLK_INT_25M
	} vbsc_clk_sel_t;

	typedef struct packed {
		logic       remote_self_test_enable;
		logic       self_test_mode;
		vbsc_clk_sel_t self_test_clock_select;
		logic       sensors_enabled;
		logic       sense_gpio0;
		logic       sense_gpio1;
		logic [6:0] voltage_gain_divisor;
		logic       sensor_gain_apply;
	} vbsc_ctrl_t;

endpackage : vbsc_pkg

// ===== logic/vbsc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module vbsc_regs (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Video packet filter
	input  wire logic              pkt_valid,
	input  wire logic [5:0]        pkt_data_type,
	input  wire logic              video_mode_hundred,
	output logic                   pkt_pass,
	// Frame and line valid pins
	input  wire logic              frame_valid_pin,
	input  wire logic              line_valid_pin,
	output logic                   frame_valid,
	output logic                   line_valid,
	// Forward channel parity injection
	input  wire logic              fc_parity_slot,
	output logic                   fc_parity_err_inject,
	output logic      [6:0]        fc_errors_remaining,
	// Self-test and sensor settings
	output vbsc_pkg::vbsc_ctrl_t   ctrl
);

	// ************
	// Reset release
	// ************
	logic rst_meta;
	logic rst_sync_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ************
	// Helpers
	// ************
	function automatic logic is_long_type(input logic [5:0] dt);
		is_long_type = dt[5] | dt[4];
	endfunction : is_long_type

	function automatic logic is_yuv10_type(input logic [5:0] dt);
		is_yuv10_type = (dt == vbsc_pkg::DT_YUV10_A) || (dt == vbsc_pkg::DT_YUV10_B) ||
			(dt == vbsc_pkg::DT_YUV10_C);
	endfunction : is_yuv10_type

	// ************
	// Registers
	// ************
	logic [7:0] video_filter_config;
	logic [7:0] video_type_match_value;
	logic [6:0] injected_error_count;
	logic       inject_parity_errors;
	logic [7:0] self_test_control;
	logic [7:0] sensor_voltage_gain;
	logic [7:0] sensor_control_first;
	logic [7:0] sensor_control_second;

	// ************
	// Write decode
	// ************
	wire logic wr_cfg    = reg_wr && (reg_addr == vbsc_pkg::OFS_VIDEO_FILTER_CONFIG);
	wire logic wr_match  = reg_wr && (reg_addr == vbsc_pkg::OFS_VIDEO_TYPE_MATCH_VALUE);
	wire logic wr_inject = reg_wr && (reg_addr == vbsc_pkg::OFS_PARITY_ERROR_INJECTION);
	wire logic wr_test   = reg_wr && (reg_addr == vbsc_pkg::OFS_SELF_TEST_CONTROL);
	wire logic wr_gain   = reg_wr && (reg_addr == vbsc_pkg::OFS_SENSOR_VOLTAGE_GAIN);
	wire logic wr_sen0   = reg_wr && (reg_addr == vbsc_pkg::OFS_SENSOR_CONTROL_FIRST);
	wire logic wr_sen1   = reg_wr && (reg_addr == vbsc_pkg::OFS_SENSOR_CONTROL_SECOND);

	// ************
	// Field views
	// ************
	wire logic any_long_type_pass = video_filter_config[vbsc_pkg::BIT_ANY_LONG_TYPE_PASS];
	wire logic type_match_enable  = video_filter_config[vbsc_pkg::BIT_TYPE_MATCH_ENABLE];
	wire logic yuv10_pass_enable  = video_filter_config[vbsc_pkg::BIT_YUV10_PASS_ENABLE];
	wire logic frame_valid_invert = video_filter_config[vbsc_pkg::BIT_FRAME_VALID_INVERT];
	wire logic line_valid_invert  = video_filter_config[vbsc_pkg::BIT_LINE_VALID_INVERT];
	wire logic [5:0] type_match_value = video_type_match_value[5:0];
	wire logic [3:0] forced_error_enable = self_test_control[7:4];
	wire logic local_self_test_enable = self_test_control[vbsc_pkg::BIT_LOCAL_SELF_TEST];

	// Match value frozen while matching is live
	wire logic match_write_ok = wr_match && !type_match_enable;

	// ************
	// Filter config register
	// ************
	wire logic [7:0] next_video_filter_config =
		wr_cfg ? reg_wdata : video_filter_config;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			video_filter_config <= vbsc_pkg::RST_VIDEO_FILTER_CONFIG;
		end else begin
			video_filter_config <= next_video_filter_config;
		end
	end

	// ************
	// Match value register
	// ************
	wire logic [7:0] next_video_type_match_value =
		match_write_ok ? reg_wdata : video_type_match_value;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			video_type_match_value <= vbsc_pkg::RST_VIDEO_TYPE_MATCH_VALUE;
		end else begin
			video_type_match_value <= next_video_type_match_value;
		end
	end

	// ************
	// Error count register
	// ************
	wire logic [6:0] next_injected_error_count =
		wr_inject ? reg_wdata[6:0] : injected_error_count;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			injected_error_count <= vbsc_pkg::RST_INJECTED_ERROR_COUNT;
		end else begin
			injected_error_count <= next_injected_error_count;
		end
	end

	// ************
	// Self-test control register
	// ************
	wire logic [7:0] next_self_test_control =
		wr_test ? reg_wdata : self_test_control;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			self_test_control <= vbsc_pkg::RST_SELF_TEST_CONTROL;
		end else begin
			self_test_control <= next_self_test_control;
		end
	end

	// ************
	// Voltage gain register
	// ************
	wire logic [7:0] next_sensor_voltage_gain =
		wr_gain ? reg_wdata : sensor_voltage_gain;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sensor_voltage_gain <= vbsc_pkg::RST_SENSOR_VOLTAGE_GAIN;
		end else begin
			sensor_voltage_gain <= next_sensor_voltage_gain;
		end
	end

	// ************
	// Sensor control first register
	// ************
	wire logic [7:0] next_sensor_control_first =
		wr_sen0 ? reg_wdata : sensor_control_first;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sensor_control_first <= vbsc_pkg::RST_SENSOR_CONTROL_FIRST;
		end else begin
			sensor_control_first <= next_sensor_control_first;
		end
	end

	// ************
	// Sensor control second register
	// ************
	wire logic [7:0] next_sensor_control_second =
		wr_sen1 ? reg_wdata : sensor_control_second;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sensor_control_second <= vbsc_pkg::RST_SENSOR_CONTROL_SECOND;
		end else begin
			sensor_control_second <= next_sensor_control_second;
		end
	end

	// ************
	// Parity error injection
	// ************
	logic       self_test_prev;
	logic [6:0] remaining;
	wire logic  injector_idle    = (remaining == 7'h00);
	wire logic  force_allowed    = (forced_error_enable != 4'h0);
	wire logic  self_test_entry  = local_self_test_enable && !self_test_prev;
	wire logic  inject_start     = injector_idle && force_allowed &&
		(inject_parity_errors || self_test_entry);
	wire logic  inject_now       = fc_parity_slot && !injector_idle;
	wire logic  inject_request   = wr_inject && reg_wdata[vbsc_pkg::BIT_INJECT_PARITY_ERRS];
	wire logic [6:0] start_count = wr_inject ? reg_wdata[6:0] : injected_error_count;

	// ************
	// Injection next state
	// ************
	logic [6:0] next_remaining;
	logic       next_inject;

	always_comb begin
		next_remaining = remaining;
		if (inject_start) begin
			next_remaining = start_count;
		end else if (inject_now) begin
			next_remaining = remaining - 7'h01;
		end
	end

	// Request held until the injector takes it, then self-clears; cleared at once while bits 7:4 are zero
	always_comb begin
		next_inject = inject_parity_errors;
		if (inject_request) begin
			next_inject = 1'b1;
		end else if (inject_start || !force_allowed) begin
			next_inject = 1'b0;
		end
	end

	// ************
	// Injection state
	// ************
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			self_test_prev <= 1'b0;
		end else begin
			self_test_prev <= local_self_test_enable;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			remaining <= 7'h00;
		end else begin
			remaining <= next_remaining;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			inject_parity_errors <= 1'b0;
		end else begin
			inject_parity_errors <= next_inject;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fc_parity_err_inject <= 1'b0;
		end else begin
			fc_parity_err_inject <= inject_now && !inject_start;
		end
	end

	assign fc_errors_remaining = remaining;

	// ************
	// Video packet filter
	// ************
	wire logic pass_any   = any_long_type_pass && is_long_type(pkt_data_type);
	wire logic pass_match = type_match_enable && (pkt_data_type == type_match_value) &&
		is_long_type(type_match_value);
	wire logic pass_yuv   = yuv10_pass_enable && video_mode_hundred &&
		is_yuv10_type(pkt_data_type);

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pkt_pass <= 1'b0;
		end else begin
			pkt_pass <= pkt_valid && (pass_any || pass_match || pass_yuv);
		end
	end

	// ************
	// Frame and line valid polarity
	// ************
	logic [1:0] fv_sync;
	logic [1:0] lv_sync;

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fv_sync     <= 2'h0;
			frame_valid <= 1'b0;
		end else begin
			fv_sync     <= {fv_sync[0], frame_valid_pin};
			frame_valid <= fv_sync[1] ^ frame_valid_invert;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lv_sync    <= 2'h0;
			line_valid <= 1'b0;
		end else begin
			lv_sync    <= {lv_sync[0], line_valid_pin};
			line_valid <= lv_sync[1] ^ line_valid_invert;
		end
	end

	// ************
	// Self-test and sensor settings
	// ************
	wire logic [1:0] clk_sel_field = self_test_control[2:1];
	wire vbsc_pkg::vbsc_clk_sel_t clk_sel_dec =
		clk_sel_field[1] ? vbsc_pkg::VBSC_CLK_INT_25M :
		(clk_sel_field[0] ? vbsc_pkg::VBSC_CLK_INT_50M : vbsc_pkg::VBSC_CLK_SYSTEM);

	vbsc_pkg::vbsc_ctrl_t next_ctrl;

	assign next_ctrl.remote_self_test_enable =
		self_test_control[vbsc_pkg::BIT_REMOTE_SELF_TEST];
	assign next_ctrl.self_test_mode         = local_self_test_enable;
	assign next_ctrl.self_test_clock_select = clk_sel_dec;
	assign next_ctrl.sensors_enabled        =
		(sensor_control_first[3:2] == vbsc_pkg::SENSOR_ENABLED);
	assign next_ctrl.sense_gpio0            = sensor_control_first[0];
	assign next_ctrl.sense_gpio1            = sensor_control_first[1];
	assign next_ctrl.voltage_gain_divisor   = sensor_voltage_gain[6:0];
	assign next_ctrl.sensor_gain_apply      =
		sensor_control_second[vbsc_pkg::BIT_SENSE_GAIN_ENABLE];

	// ************
	// Control outputs
	// ************
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl <= '0;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ************
	// Read back
	// ************
	logic [7:0] read_mux;

	always_comb begin
		unique case (reg_addr)
			vbsc_pkg::OFS_VIDEO_FILTER_CONFIG:    read_mux = video_filter_config;
			vbsc_pkg::OFS_VIDEO_TYPE_MATCH_VALUE: read_mux = video_type_match_value;
			vbsc_pkg::OFS_PARITY_ERROR_INJECTION: read_mux = {inject_parity_errors,
				injected_error_count};
			vbsc_pkg::OFS_SELF_TEST_CONTROL:      read_mux = self_test_control;
			vbsc_pkg::OFS_SENSOR_VOLTAGE_GAIN:    read_mux = sensor_voltage_gain;
			vbsc_pkg::OFS_SENSOR_CONTROL_FIRST:   read_mux = sensor_control_first;
			vbsc_pkg::OFS_SENSOR_CONTROL_SECOND:  read_mux = sensor_control_second;
			default:                              read_mux = vbsc_pkg::READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? read_mux : 8'h00;
		end
	end

endmodule : vbsc_regs

`default_nettype wire

// ===== verif/vbsc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Checker
// ************
module vbsc_properties (
	// Clock and register port
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic [7:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [7:0]           reg_rdata,
	// Filter and pins
	input wire logic                 pkt_valid,
	input wire logic [5:0]           pkt_data_type,
	input wire logic                 video_mode_hundred,
	input wire logic                 pkt_pass,
	input wire logic                 frame_valid_pin,
	input wire logic                 line_valid_pin,
	input wire logic                 frame_valid,
	input wire logic                 line_valid,
	// Injection and settings
	input wire logic                 fc_parity_slot,
	input wire logic                 fc_parity_err_inject,
	input wire logic [6:0]           fc_errors_remaining,
	input wire vbsc_pkg::vbsc_ctrl_t ctrl
);
	// Shadow of the filter config register
	logic [7:0] cfg;
	wire        w14 = reg_wr && reg_addr == 8'h14;
	wire        w18 = reg_wr && reg_addr == 8'h18;
	wire [5:0]  dt  = pkt_data_type;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cfg <= 8'h00;
		else if (reg_wr && reg_addr == 8'h10)
			cfg <= reg_wdata;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_any_long_pass: assert property (pkt_valid && cfg[4] && dt[5:4] != 2'b00 |=> pkt_pass)
		else $error("long packet not passed");
	a_short_blocked: assert property (pkt_valid && dt[5:4] == 2'b00 |=> !pkt_pass)
		else $error("short packet passed");
	a_idle_no_pass: assert property (!pkt_valid |=> !pkt_pass)
		else $error("pass without packet");
	a_yuv_mode_pass: assert property (pkt_valid && cfg[2] && video_mode_hundred
		&& dt inside {6'h19, 6'h1d, 6'h1f} |=> pkt_pass) else $error("yuv not passed");
	a_frame_polarity: assert property (($stable(frame_valid_pin) && $stable(cfg[1]))[*8]
		|-> frame_valid == (frame_valid_pin ^ cfg[1])) else $error("frame valid polarity");
	a_line_polarity: assert property (($stable(line_valid_pin) && $stable(cfg[0]))[*8]
		|-> line_valid == (line_valid_pin ^ cfg[0])) else $error("line valid polarity");
	a_inject_cause: assert property (fc_parity_err_inject |-> $past(fc_parity_slot)
		&& $past(fc_errors_remaining) != 7'h00) else $error("inject without cause");
	a_count_down: assert property (fc_parity_slot && fc_errors_remaining != 7'h00 |=>
		fc_parity_err_inject && fc_errors_remaining == $past(fc_errors_remaining) - 7'h01)
		else $error("count not decremented");
	a_self_test_bits: assert property (w14 |-> ##2 ctrl.self_test_mode ==
		$past(reg_wdata[3], 2) && ctrl.remote_self_test_enable == $past(reg_wdata[0], 2))
		else $error("self test bits");
	a_gain_apply: assert property (w18 |-> ##2
		ctrl.sensor_gain_apply == $past(reg_wdata[7], 2)) else $error("gain apply bit");
	c_inject: cover property (fc_parity_err_inject);
	c_pass: cover property (pkt_pass);
	c_self_test: cover property (ctrl.self_test_mode);
endmodule : vbsc_properties
bind vbsc_regs vbsc_properties u_vbsc_properties (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_data_type(pkt_data_type),
	.video_mode_hundred(video_mode_hundred), .pkt_pass(pkt_pass),
	.frame_valid_pin(frame_valid_pin), .line_valid_pin(line_valid_pin),
	.frame_valid(frame_valid), .line_valid(line_valid), .fc_parity_slot(fc_parity_slot),
	.fc_parity_err_inject(fc_parity_err_inject), .fc_errors_remaining(fc_errors_remaining),
	.ctrl(ctrl));
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
	logic                 clk_sys = 1'b0;
	logic                 rst_n   = 1'b0;
	logic [7:0]           addr    = 8'h00;
	logic [7:0]           wdata   = 8'h00;
	logic                 wr_s    = 1'b0;
	logic                 rd_s    = 1'b0;
	logic                 pv      = 1'b0;
	logic                 mode    = 1'b0;
	logic [5:0]           pdt     = 6'h00;
	logic                 fv_pin  = 1'b0;
	logic                 lv_pin  = 1'b0;
	logic                 slot    = 1'b0;
	logic [7:0]           rdata;
	logic                 pass, fv, lv, inj;
	logic [6:0]           remain;
	vbsc_pkg::vbsc_ctrl_t ctrl;
	int                   fails = 0;
	int                   compares = 0;
	vbsc_pkg::vbsc_clk_sel_t exp_sel;
	logic [7:0] offs [7] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18};
	logic [7:0] rsts [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h3c, 8'h80};
	logic [5:0] yuv [3]  = '{6'h19, 6'h1d, 6'h1f};
	vbsc_regs u_vbsc_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .pkt_valid(pv),
		.pkt_data_type(pdt), .video_mode_hundred(mode), .pkt_pass(pass),
		.frame_valid_pin(fv_pin), .line_valid_pin(lv_pin), .frame_valid(fv),
		.line_valid(lv), .fc_parity_slot(slot), .fc_parity_err_inject(inj),
		.fc_errors_remaining(remain), .ctrl(ctrl));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr_s <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd_s <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd
	task automatic pk(input logic [5:0] t, input logic e);
		@(posedge clk_sys);
		pv  <= 1'b1;
		pdt <= t;
		@(posedge clk_sys);
		pv <= 1'b0;
		#1;
		`CHK("pass", e, pass)
	endtask : pk
	task automatic sl(input logic e);
		@(posedge clk_sys);
		slot <= 1'b1;
		@(posedge clk_sys);
		slot <= 1'b0;
		#1;
		`CHK("inject", e, inj)
	endtask : sl
	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#1000000;
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 7; i++)
			rd(offs[i], rsts[i]);
		rd(8'h12, 8'h00);
		`CHK("sens_en", 1'b1, ctrl.sensors_enabled)
		`CHK("divisor", 7'h20, ctrl.voltage_gain_divisor)
		`CHK("gain_on", 1'b1, ctrl.sensor_gain_apply)
		$display("reset test done");
		for (int v = 0; v < 8; v += 2) begin
			wr(8'h14, 8'(v + 9));
			exp_sel = v[2] ? vbsc_pkg::VBSC_CLK_INT_25M :
				(v[1] ? vbsc_pkg::VBSC_CLK_INT_50M : vbsc_pkg::VBSC_CLK_SYSTEM);
			`CHK("clk_sel", exp_sel, ctrl.self_test_clock_select)
			`CHK("self_test", 1'b1, ctrl.self_test_mode)
			`CHK("remote", 1'b1, ctrl.remote_self_test_enable)
		end
		for (int v = 0; v < 4; v++) begin
			wr(8'h17, 8'(v) | 8'h3c);
			`CHK("gpio0", v[0], ctrl.sense_gpio0)
			`CHK("gpio1", v[1], ctrl.sense_gpio1)
		end
		wr(8'h17, 8'h30);
		`CHK("sens_off", 1'b0, ctrl.sensors_enabled)
		wr(8'h15, 8'h40);
		rd(8'h15, 8'h40);
		`CHK("divisor", 7'h40, ctrl.voltage_gain_divisor)
		wr(8'h18, 8'h00);
		`CHK("gain_off", 1'b0, ctrl.sensor_gain_apply)
		$display("control test done");
		wr(8'h10, 8'h10);
		pk(6'h2a, 1'b1);
		pk(6'h05, 1'b0);
		wr(8'h11, 8'h2a);
		wr(8'h10, 8'h08);
		wr(8'h11, 8'h33);
		rd(8'h11, 8'h2a);
		pk(6'h2a, 1'b1);
		pk(6'h2b, 1'b0);
		@(posedge clk_sys);
		mode <= 1'b1;
		pk(6'h2a, 1'b1);
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h05);
		wr(8'h10, 8'h08);
		pk(6'h05, 1'b0);
		wr(8'h10, 8'h04);
		for (int i = 0; i < 3; i++)
			pk(yuv[i], 1'b1);
		pk(6'h1a, 1'b0);
		@(posedge clk_sys);
		mode <= 1'b0;
		pk(6'h19, 1'b0);
		$display("filter test done");
		wr(8'h10, 8'h03);
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK("fv", 1'b1, fv)
		`CHK("lv", 1'b1, lv)
		@(posedge clk_sys);
		fv_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK("fv", 1'b0, fv)
		`CHK("lv", 1'b1, lv)
		$display("polarity test done");
		wr(8'h14, 8'h10);
		wr(8'h13, 8'h82);
		rd(8'h13, 8'h02);
		`CHK("remain", 7'h02, remain)
		sl(1'b1);
		sl(1'b1);
		sl(1'b0);
		wr(8'h13, 8'h03);
		wr(8'h14, 8'h18);
		rd(8'h14, 8'h18);
		`CHK("remain", 7'h03, remain)
		repeat (3) sl(1'b1);
		wr(8'h14, 8'h00);
		wr(8'h13, 8'h81);
		rd(8'h13, 8'h01);
		`CHK("remain", 7'h00, remain)
		$display("inject test done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
